// [design/frs_delay_timer.sv]
// Purpose: counts 2**exp time units, each unit_cyc clock cycles long
// Assumes: start restarts the count; its own cycle is the first of the span
// Notes:   expired stays high until the next start
`timescale 1ns/10ps
module frs_delay_timer
  import frs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic [15:0] unit_cyc,
  input  wire logic [2:0]  exp,
  output logic             expired
);

  logic [15:0] pre;
  logic [7:0]  units;
  wire  [7:0]  target    = 8'h01 << exp;
  wire  [15:0] pre_inc   = pre + 16'h0001;
  wire  [7:0]  units_inc = units + 8'h01;
  // a zero unit is taken as one cycle so the timer cannot stall
  wire         unit_end  = (pre_inc >= unit_cyc);
  // the start cycle counts as the first cycle of the span, so a span of n
  // cycles ends n edges after start and chained spans keep their pitch
  wire         one_cyc   = (unit_cyc <= 16'h0001);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pre     <= 16'h0000;
      units   <= 8'h00;
      expired <= 1'b0;
    end else if (clk_en) begin
      if (start) begin
        pre     <= one_cyc ? 16'h0000 : 16'h0001;
        units   <= one_cyc ? 8'h01 : 8'h00;
        expired <= one_cyc && (target == 8'h01);
      end else if (!expired) begin
        pre <= unit_end ? 16'h0000 : pre_inc;
        if (unit_end) begin
          units   <= units_inc;
          expired <= (units_inc == target);
        end
      end
    end
  end

endmodule

// [design/frs_retry_count.sv]
// Purpose: remaining restart attempts of one retry sequence
// Assumes: load and consume are never high together
// Notes:   the all-ones setting never runs out
`timescale 1ns/10ps
module frs_retry_count
  import frs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       clk_en,
  input  wire logic       load,
  input  wire logic [2:0] retries,
  input  wire logic       consume,
  output logic [2:0]      left,
  output logic            unlimited
);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      left      <= 3'h0;
      unlimited <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        left      <= retries;
        unlimited <= (retries == RETRY_FOREVER);
      end else if (consume && !unlimited && left != 3'h0) begin
        left <= left - 3'h1;
      end
    end
  end

endmodule

// [design/frs_sequencer.sv]
// Purpose: fault response and restart sequencer with APB registers
// Assumes: fault_present, ctrl_pin_on, bias_ok and fault_shutdown are
//          synchronous to clk_sys
// Notes:   zero-wait APB slave; unmapped addresses answer pslverr
//
// Functional notes
// - code 11 keeps output off while fault persists, resumes when gone.
// - latched fault cleared by bit clear, clear command, reset, off-on, bias loss.
// - retry field 000 means no restart, output off until cleared.
// - retry 1..6 tries that many restarts, then off until cleared.
// - restart starts spaced by 2**delay field time units.
// - retry 111 restarts forever until off, bias loss or other fault.
// - delay field counts 2**n time units; unit from its own register.
// - code 01 runs for the delay then retries; code 10 shuts down at once.
`timescale 1ns/10ps
module frs_sequencer
  import frs_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        fault_present,
  input  wire logic        fault_shutdown,
  input  wire logic        ctrl_pin_on,
  input  wire logic        bias_ok,
  output logic             out_enable,
  output logic             fault_latched,
  output logic             irq
);

  // ==========================================================
  // registers and state
  frs_resp_t        resp;
  logic             op_on;
  logic [15:0]      unit_cyc;
  logic [EVT_W-1:0] irq_stat;
  logic [EVT_W-1:0] irq_mask;
  frs_state_t       state;
  frs_state_t       next_state;
  logic             fault_prev;
  logic             tmr_expired;
  logic [2:0]       rc_left;
  logic             rc_unlimited;

  // ==========================================================
  // APB decode
  wire setup    = psel && !penable;
  wire access   = psel && penable && pready;
  wire wr       = access && pwrite;
  wire rd       = access && !pwrite;
  wire hit_ctrl = (paddr == OFS_CTRL);
  wire hit_resp = (paddr == OFS_RESPONSE);
  wire hit_unit = (paddr == OFS_UNIT);
  wire hit_stat = (paddr == OFS_STATUS);
  wire hit_istat = (paddr == OFS_IRQ_STAT);
  wire hit_imask = (paddr == OFS_IRQ_MASK);
  wire mapped   = hit_ctrl | hit_resp | hit_unit | hit_stat | hit_istat | hit_imask;

  // clear sources driven by software
  wire clear_cmd  = wr && hit_ctrl && pwdata[CTRL_CLEAR_BIT];
  wire clear_bit  = wr && hit_stat && pwdata[STAT_LATCH_BIT];
  wire clear_sw   = clear_cmd || clear_bit;
  // output is on only when pin, command and bias all agree
  wire run_cmd    = ctrl_pin_on && op_on && bias_ok;
  // edge of the fault level, used for the detect event only
  wire fault_rise = fault_present && !fault_prev;

  wire [31:0] stat_word = {20'h00000, 1'b0, state, 1'b0, rc_left,
                           1'b0, fault_present, out_enable, fault_latched};
  wire [31:0] rd_mux =
      hit_ctrl  ? {31'h00000000, op_on} :
      hit_resp  ? {24'h000000, resp} :
      hit_unit  ? {16'h0000, unit_cyc} :
      hit_stat  ? stat_word :
      hit_istat ? {27'h0000000, irq_stat} :
      hit_imask ? {27'h0000000, irq_mask} : 32'h00000000;

  // ==========================================================
  // sequencing decisions
  frs_evt_t evt;
  logic     tmr_start;
  logic     rc_load;
  logic     rc_consume;
  logic     latch_set;

  // no restart left: none configured, or all spent
  wire out_of_tries = !rc_unlimited && (rc_left == 3'h0);

  always_comb begin
    next_state = state;
    tmr_start  = 1'b0;
    rc_load    = 1'b0;
    rc_consume = 1'b0;
    latch_set  = 1'b0;
    evt        = '0;
    evt.detect = fault_rise;
    case (state)
      ST_OFF: begin
        // a standing shutdown fault keeps the output from coming up
        if (run_cmd && !fault_shutdown) begin
          next_state = ST_RUN;
          rc_load    = 1'b1;
          tmr_start  = 1'b1;
        end
      end
      ST_RUN: begin
        if (!run_cmd) begin
          next_state = ST_OFF;
        end else if (fault_shutdown) begin
          next_state   = ST_HOLD;
          latch_set    = 1'b1;
          evt.shutdown = 1'b1;
        end else if (fault_present) begin
          latch_set = 1'b1;
          rc_load   = 1'b1;
          case (resp.code)
            RESP_DELAY: begin
              next_state = ST_DELAY;
              tmr_start  = 1'b1;
            end
            RESP_DISABLE: begin
              evt.shutdown = 1'b1;
              tmr_start    = 1'b1;
              next_state   = (resp.retries == RETRY_NONE) ? ST_HOLD : ST_WAIT;
            end
            RESP_FOLLOW: begin
              next_state   = ST_FOLLOW;
              evt.shutdown = 1'b1;
            end
            default: begin
              next_state = ST_RUN;
            end
          endcase
        end
      end
      ST_DELAY: begin
        if (tmr_expired) begin
          if (fault_present) begin
            evt.shutdown = 1'b1;
            tmr_start    = 1'b1;
            next_state   = (resp.retries == RETRY_NONE) ? ST_HOLD : ST_WAIT;
          end else begin
            next_state    = ST_RUN;
            evt.recovered = 1'b1;
          end
        end
      end
      ST_FOLLOW: begin
        if (!fault_present) begin
          next_state    = ST_RUN;
          evt.recovered = 1'b1;
        end
      end
      ST_WAIT: begin
        if (tmr_expired) begin
          next_state = ST_TRY;
          tmr_start  = 1'b1;
          rc_consume = 1'b1;
          evt.retry  = 1'b1;
        end
      end
      ST_TRY: begin
        // a fault anywhere in the attempt window counts as a failed restart
        if (fault_present) begin
          evt.shutdown = 1'b1;
          if (out_of_tries) begin
            next_state    = ST_HOLD;
            evt.exhausted = 1'b1;
          end else begin
            next_state = ST_WAIT;
          end
        end else if (tmr_expired) begin
          next_state    = ST_RUN;
          evt.recovered = 1'b1;
        end
      end
      ST_HOLD: begin
        // only a clear, an off command or bias loss leaves hold
        next_state = ST_HOLD;
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
    // off command, bias loss and software clears outside follow override the sequence
    if (state != ST_OFF && state != ST_RUN) begin
      if (!run_cmd) begin
        next_state = ST_OFF;
        tmr_start  = 1'b0;
        rc_consume = 1'b0;
      end else if (fault_shutdown) begin
        // a standing shutdown fault also blocks a software clear out of hold
        next_state   = ST_HOLD;
        evt.shutdown = (state != ST_HOLD);
        tmr_start    = 1'b0;
        rc_consume   = 1'b0;
      end else if (clear_sw && state != ST_FOLLOW) begin
        next_state = ST_RUN;
        rc_load    = 1'b1;
        tmr_start  = 1'b1;
        rc_consume = 1'b0;
      end
    end
  end

  // decided from next_state so the output flop moves on the state's edge
  wire next_out = (next_state == ST_RUN) || (next_state == ST_DELAY) ||
                  (next_state == ST_TRY);
  // off-then-on and bias loss clear the latch; a new fault wins over a clear
  wire latch_clr  = clear_sw || !run_cmd;
  wire next_latch = latch_set || (fault_latched && !latch_clr);
  // a read clears only the bits it returned, so an event landing between the
  // setup edge and the access edge is not lost; a new event wins over the clear
  wire [EVT_W-1:0] rd_clr     = (rd && hit_istat) ? prdata[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] next_istat = evt | (irq_stat & ~rd_clr);

  // ==========================================================
  // helpers
  // the timer counts its start cycle, so attempt starts sit exactly one span apart
  frs_delay_timer u_timer (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .clk_en   (clk_en),
    .start    (tmr_start),
    .unit_cyc (unit_cyc),
    .exp      (resp.delay),
    .expired  (tmr_expired)
  );

  frs_retry_count u_retry (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .load      (rc_load),
    .retries   (resp.retries),
    .consume   (rc_consume),
    .left      (rc_left),
    .unlimited (rc_unlimited)
  );

  // ==========================================================
  // register file
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      resp     <= frs_resp_t'(RESPONSE_RST);
      op_on    <= CTRL_ON_RST;
      unit_cyc <= UNIT_RST;
      irq_mask <= MASK_RST;
    end else if (clk_en && wr) begin
      // a refused write to an unmapped address matches no hit and changes nothing
      if (hit_ctrl) op_on <= pwdata[CTRL_ON_BIT];
      if (hit_resp) resp <= frs_resp_t'(pwdata[7:0]);
      if (hit_unit) unit_cyc <= pwdata[15:0];
      if (hit_imask) irq_mask <= pwdata[EVT_W-1:0];
    end
  end

  // ==========================================================
  // bus answer, registered one cycle after setup
  // no wait states; with clk_en low in the setup cycle pready never rises
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else if (clk_en) begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      prdata  <= (setup && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ==========================================================
  // state, outputs and interrupt
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state         <= ST_OFF;
      fault_prev    <= 1'b0;
      out_enable    <= 1'b0;
      fault_latched <= 1'b0;
      irq_stat      <= '0;
      irq           <= 1'b0;
    end else if (clk_en) begin
      state         <= next_state;
      fault_prev    <= fault_present;
      out_enable    <= next_out;
      fault_latched <= next_latch;
      irq_stat      <= next_istat;
      // registered from next_istat so irq rises with its status bit
      irq           <= |(next_istat & irq_mask);
    end
  end

endmodule

// [pkg/frs_pkg.sv]
// Purpose: shared constants and types of the fault retry sequencer
// Assumes: 32-bit APB register bus, 100 MHz clk_sys
// Notes:   one aligned word per register, narrow fields in the low bits
package frs_pkg;

  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIME_UNIT_NS  = 1000;
  localparam int UNIT_CYC      = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_RESPONSE = 8'h04;
  localparam logic [7:0] OFS_UNIT     = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // ==========================================================
  // field positions
  localparam int CTRL_ON_BIT    = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int STAT_LATCH_BIT = 0;
  localparam int STAT_OUT_BIT   = 1;
  localparam int STAT_FAULT_BIT = 2;
  localparam int STAT_LEFT_LSB  = 4;
  localparam int STAT_STATE_LSB = 8;
  localparam int EVT_W          = 5;

  // ==========================================================
  // reset values
  localparam logic [7:0]       RESPONSE_RST = 8'h80;
  localparam logic [15:0]      UNIT_RST     = 16'(UNIT_CYC);
  localparam logic             CTRL_ON_RST  = 1'b0;
  localparam logic [EVT_W-1:0] MASK_RST     = 5'h00;

  // ==========================================================
  // response byte
  localparam logic [2:0] RETRY_NONE    = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  typedef enum logic [1:0] {
    RESP_IGNORE,
    RESP_DELAY,
    RESP_DISABLE,
    RESP_FOLLOW
  } frs_code_t;

  typedef struct packed {
    frs_code_t  code;
    logic [2:0] retries;
    logic [2:0] delay;
  } frs_resp_t;

  typedef struct packed {
    logic recovered;
    logic exhausted;
    logic retry;
    logic shutdown;
    logic detect;
  } frs_evt_t;

  typedef enum logic [2:0] {
    ST_OFF,
    ST_RUN,
    ST_DELAY,
    ST_FOLLOW,
    ST_WAIT,
    ST_TRY,
    ST_HOLD
  } frs_state_t;

endpackage

// [testbench/frs_line_model.sv]
// Purpose: fault and control line driver standing in for the power stage
// Assumes: lines change just after a rising edge of clk_sys
// Notes:   levels only; the bench commands every change
`timescale 1ns/10ps
module frs_line_model (
  input  wire logic clk_sys,
  output logic      fault_present,
  output logic      fault_shutdown,
  output logic      ctrl_pin_on,
  output logic      bias_ok
);
  // ==========================================================
  // line control
  initial begin
    fault_present  = 1'b0;
    fault_shutdown = 1'b0;
    ctrl_pin_on    = 1'b1;
    bias_ok        = 1'b1;
  end

  task automatic drive(input logic f, input logic s, input logic p, input logic b);
    @(posedge clk_sys);
    fault_present  <= f;
    fault_shutdown <= s;
    ctrl_pin_on    <= p;
    bias_ok        <= b;
  endtask
endmodule

// [testbench/frs_sequencer_checker.sv]
// Purpose: port-level assertions of the fault retry sequencer
// Assumes: clk_en low only while the bus is idle
// Notes:   sees only the top module's ports
`timescale 1ns/10ps
module frs_sequencer_checker
  import frs_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        fault_present,
  input wire logic        fault_shutdown,
  input wire logic        ctrl_pin_on,
  input wire logic        bias_ok,
  input wire logic        out_enable,
  input wire logic        fault_latched
);
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_setup;
    psel && !penable && clk_en;
  endsequence

  chk_ready_after: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_err_map: assert property (s_setup ##0 (paddr > 8'h14) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_idle_data: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside answer");
  chk_pin_off: assert property (!ctrl_pin_on |=> !out_enable)
    else $error("output on while pin off");
  chk_bias_off: assert property (!bias_ok |=> !out_enable && !fault_latched)
    else $error("bias loss left output or latch");
  chk_other_fault: assert property (fault_shutdown |=> !out_enable)
    else $error("other fault did not shut down");
  chk_latch_cause: assert property ($rose(fault_latched) |-> $past(fault_present) || $past(fault_shutdown))
    else $error("latch set without fault");
  chk_on_needs: assert property (out_enable |-> $past(ctrl_pin_on) && $past(bias_ok))
    else $error("output on without pin and bias");
endmodule

bind frs_sequencer frs_sequencer_checker chk_inst (
  .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .fault_present(fault_present), .fault_shutdown(fault_shutdown),
  .ctrl_pin_on(ctrl_pin_on), .bias_ok(bias_ok), .out_enable(out_enable),
  .fault_latched(fault_latched)
);

// [testbench/frs_sequencer_tb.sv]
// Purpose: self-checking bench of the fault retry sequencer
// Assumes: time unit shortened to 2 cycles through the unit register
// Notes:   restart starts counted on rising edges of out_enable
`timescale 1ns/10ps
module frs_sequencer_tb;
  import frs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic        clk_en  = 1'b1;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, rerr;
  logic        fp, fs, pin, bias, out_enable, fault_latched, irq, oe_q;
  int          err_total, num_checks, rises, gap, last_rise, cyc;

  always #5 clk_sys = ~clk_sys;

  frs_sequencer frs_sequencer_inst (
    .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fault_present(fp), .fault_shutdown(fs), .ctrl_pin_on(pin),
    .bias_ok(bias), .out_enable(out_enable), .fault_latched(fault_latched), .irq(irq));
  frs_line_model frs_line_model_inst (
    .clk_sys(clk_sys), .fault_present(fp), .fault_shutdown(fs), .ctrl_pin_on(pin),
    .bias_ok(bias));

  // ==========================================================
  // restart start monitor: count and spacing in cycles
  always @(posedge clk_sys) begin
    if (out_enable === 1'b1 && oe_q === 1'b0) begin
      rises++;
      gap = cyc - last_rise;
      last_rise = cyc;
    end
    oe_q = out_enable;
    cyc++;
  end

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd      = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic setup();
    apb(1'b1, OFS_UNIT, 32'h2);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    apb(1'b1, OFS_CTRL, 32'h1);
    idle(3);
    chk(out_enable, 1'b1, "output on after setup");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #300000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    apb(1'b0, OFS_RESPONSE, 32'h0);
    chk(rd, 32'h80, "response reset value");
    apb(1'b0, 8'h20, 32'h0);
    chk(rerr, 1'b1, "unmapped refused");
    setup();
    $display("test registers done");
    // code 10, no retry, then irq and bit clear
    frs_line_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b1);
    frs_line_model_inst.drive(1'b0, 1'b0, 1'b1, 1'b1);
    idle(3);
    chk({out_enable, fault_latched, irq}, 3'b011, "shut on fault");
    idle(30);
    chk(out_enable, 1'b0, "no restart");
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk(rd[0], 1'b1, "detect event");
    idle(2);
    chk(irq, 1'b0, "irq cleared by read");
    apb(1'b1, OFS_STATUS, 32'h1);
    idle(3);
    chk({out_enable, fault_latched}, 2'b10, "bit clear restarts");
    $display("test no retry done");
    // code 11 with irq masked
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    apb(1'b1, OFS_RESPONSE, 32'hc0);
    frs_line_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b1);
    idle(6);
    chk({out_enable, irq}, 2'b00, "off while fault, irq masked");
    frs_line_model_inst.drive(1'b0, 1'b0, 1'b1, 1'b1);
    idle(4);
    chk(out_enable, 1'b1, "resumes when fault gone");
    $display("test follow done");
    // counted retries, delay 2 units, alternating clear kinds
    for (int r = 1; r <= 6; r++) begin
      apb(1'b1, OFS_RESPONSE, {24'h0, 2'b10, 3'(r), 3'd1});
      rises = 0;
      frs_line_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b1);
      idle(80);
      chk(rises, r, "restart count");
      if (r > 1) chk(gap, 4, "start to start spacing");
      frs_line_model_inst.drive(1'b0, 1'b0, 1'b1, 1'b1);
      idle(10);
      chk(out_enable, 1'b0, "off after exhausted");
      apb(1'b1, r[0] ? OFS_CTRL : OFS_STATUS, r[0] ? 32'h3 : 32'h1);
      idle(3);
      chk(out_enable, 1'b1, "fresh start after clear");
    end
    $display("test counted retries done");
    // code 01 keeps running for 4 units then one retry
    apb(1'b1, OFS_RESPONSE, 32'h4a);
    frs_line_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b1);
    idle(4);
    chk(out_enable, 1'b1, "runs during delay");
    idle(40);
    chk(out_enable, 1'b0, "off after delay and retry");
    frs_line_model_inst.drive(1'b0, 1'b0, 1'b1, 1'b0);
    idle(3);
    frs_line_model_inst.drive(1'b0, 1'b0, 1'b1, 1'b1);
    idle(3);
    chk({out_enable, fault_latched}, 2'b10, "bias loss clears");
    $display("test delayed response done");
    // endless retries, stopped by the pin, then other fault
    apb(1'b1, OFS_RESPONSE, 32'hb8);
    rises = 0;
    frs_line_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b1);
    idle(60);
    chk(rises > 10, 1'b1, "keeps restarting");
    chk(gap, 2, "one unit spacing");
    frs_line_model_inst.drive(1'b1, 1'b0, 1'b0, 1'b1);
    idle(3);
    chk(out_enable, 1'b0, "pin off stops");
    frs_line_model_inst.drive(1'b0, 1'b0, 1'b1, 1'b1);
    idle(3);
    chk(out_enable, 1'b1, "off then on clears");
    frs_line_model_inst.drive(1'b0, 1'b1, 1'b1, 1'b1);
    frs_line_model_inst.drive(1'b0, 1'b0, 1'b1, 1'b1);
    idle(20);
    chk(out_enable, 1'b0, "other fault holds off");
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    idle(1);
    chk({out_enable, fault_latched}, 2'b00, "reset clears");
    setup();
    $display("test endless done");
    // clock enable low freezes the sequence; response is back at its reset value
    @(posedge clk_sys);
    clk_en <= 1'b0;
    frs_line_model_inst.drive(1'b1, 1'b0, 1'b1, 1'b1);
    idle(5);
    chk({out_enable, fault_latched}, 2'b10, "frozen while disabled");
    @(posedge clk_sys);
    clk_en <= 1'b1;
    idle(3);
    chk({out_enable, fault_latched}, 2'b01, "shuts once enabled");
    $display("test clock enable done");
    stop_test();
  end
endmodule
